// File: rtl/cbe_branch_unit.sv
/*
  Branch execution unit: fetches and executes the relative jump on a
  clear zero flag, the indirect jumps through the pointer pair and the
  two index registers, and the decrement-and-branch loop instruction.
  Assumes program memory returns the addressed byte on mem_data_i by
  the third clock state of a read and that register inputs are stable
  while busy_o is high.
*/
// Function
// - Opcode 20 is jump on clear zero
// - Taken: add displacement, 3 cycles, 12 states
// - Zero set: fall through, 2 cycles, 7
// - Reach spans minus 126 to plus 129
// - Displacement added to twice advanced counter
// - Pointer pair jump: one cycle, four states
// - DD E9 loads first index, 8 states
// - FD E9 loads second index likewise
// - Opcode 10 decrements counter, nonzero branches, 13
// - Counter zero falls through, 8 states
// - Loop decides on counter, flags untouched
module cbe_branch_unit
  import cbe_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [15:0] pc_i,
  input wire logic zero_flag_i,
  input wire logic [7:0] loop_count_i,
  input wire logic [15:0] pointer_pair_i,
  input wire logic [15:0] first_index_i,
  input wire logic [15:0] second_index_i,
  input wire logic [7:0] mem_data_i,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic busy_o,
  output logic done_o,
  output logic unsupported_o,
  output logic [15:0] program_counter_o,
  output logic [7:0] loop_count_o,
  output logic loop_count_we_o,
  output logic [3:0] tstate_count_o,
  output logic [1:0] mcycle_count_o
);
  import cbe_pkg::*;

  typedef struct packed {
    cbe_state_e st;
    logic [2:0] t;
    logic [7:0] op;
    logic second_sel;
    logic [7:0] disp;
    logic [15:0] pc;
    logic [15:0] op_addr;
    logic [7:0] cnt;
    logic cnt_we;
    logic done;
    logic unsup;
    logic [3:0] tc;
    logic [1:0] mc;
  } cbe_state_s;

  cbe_state_s s_reg;
  cbe_state_s s_next;
  logic [2:0] fetch_last;
  logic take;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.unsup = 1'b0;
    s_next.cnt_we = 1'b0;
    fetch_last = (s_reg.op == OP_LOOP) ? T_FETCH_LOOP - 3'h1
                                       : T_FETCH - 3'h1;
    take = 1'b0;
    if (s_reg.st != ST_IDLE) begin
      s_next.t = s_reg.t + 3'h1;
      s_next.tc = s_reg.tc + 4'h1;
    end
    case (s_reg.st)
      ST_IDLE: begin
        if (start_i) begin
          s_next.st = ST_FETCH;
          s_next.pc = pc_i;
          s_next.op_addr = pc_i;
          s_next.op = 8'h00;
          s_next.t = 3'h0;
          s_next.tc = 4'h0;
          s_next.mc = 2'h0;
        end
      end
      ST_FETCH: begin
        if (s_reg.t == T_SAMPLE) begin
          s_next.op = mem_data_i;
        end
        if (s_reg.t == fetch_last) begin
          s_next.t = 3'h0;
          s_next.mc = s_reg.mc + 2'h1;
          s_next.pc = s_reg.pc + 16'h0001;
          case (s_reg.op)
            OP_REL_NZ: s_next.st = ST_DISP;
            OP_LOOP: begin
              s_next.cnt = loop_count_i - 8'h01;
              s_next.cnt_we = 1'b1;
              s_next.st = ST_DISP;
            end
            OP_JUMP_PTR: begin
              s_next.pc = pointer_pair_i;
              s_next.st = ST_IDLE;
              s_next.done = 1'b1;
            end
            OP_PFX_FIRST, OP_PFX_SECOND: begin
              s_next.second_sel = (s_reg.op == OP_PFX_SECOND);
              s_next.st = ST_PFX;
            end
            default: begin
              s_next.st = ST_IDLE;
              s_next.done = 1'b1;
              s_next.unsup = 1'b1;
            end
          endcase
        end
      end
      ST_PFX: begin
        if (s_reg.t == T_SAMPLE) begin
          s_next.op = mem_data_i;
        end
        if (s_reg.t == T_FETCH - 3'h1) begin
          s_next.t = 3'h0;
          s_next.mc = s_reg.mc + 2'h1;
          s_next.st = ST_IDLE;
          s_next.done = 1'b1;
          if (s_reg.op == OP_JUMP_PTR) begin
            s_next.pc = s_reg.second_sel ? second_index_i : first_index_i;
          end else begin
            s_next.pc = s_reg.pc + 16'h0001;
            s_next.unsup = 1'b1;
          end
        end
      end
      ST_DISP: begin
        if (s_reg.t == T_SAMPLE) begin
          s_next.disp = mem_data_i;
          s_next.t = 3'h0;
          s_next.mc = s_reg.mc + 2'h1;
          s_next.pc = s_reg.pc + 16'h0001;
          if (s_reg.op == OP_LOOP) begin
            take = (s_reg.cnt != 8'h00);
          end else begin
            take = !zero_flag_i;
          end
          s_next.st = take ? ST_ADD : ST_IDLE;
          s_next.done = !take;
        end
      end
      ST_ADD: begin
        if (s_reg.t == T_ADD - 3'h1) begin
          s_next.t = 3'h0;
          s_next.mc = s_reg.mc + 2'h1;
          s_next.pc = s_reg.pc + {{8{s_reg.disp[7]}}, s_reg.disp};
          s_next.st = ST_IDLE;
          s_next.done = 1'b1;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // The unit has no flag outputs, so no condition flag can change.
  assign mem_addr_o = s_reg.pc;
  assign mem_rd_o = (s_reg.st == ST_FETCH) || (s_reg.st == ST_PFX) ||
                    (s_reg.st == ST_DISP);
  assign busy_o = (s_reg.st != ST_IDLE);
  assign done_o = s_reg.done;
  assign unsupported_o = s_reg.unsup;
  assign program_counter_o = s_reg.pc;
  assign loop_count_o = s_reg.cnt;
  assign loop_count_we_o = s_reg.cnt_we;
  assign tstate_count_o = s_reg.tc;
  assign mcycle_count_o = s_reg.mc;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_REL_DECODE: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (s_reg.st == ST_FETCH && s_reg.t == 3'h3 && s_reg.op == OP_REL_NZ)
    |=> (s_reg.st == ST_DISP) ##3 (s_reg.st != ST_DISP))
    else $error("relative jump opcode not decoded");

  AST_REL_TAKEN_TIME: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (done_o && !unsupported_o && s_reg.op == OP_REL_NZ && s_reg.mc == 2'h3)
    |-> (tstate_count_o == TT_REL_TAKEN))
    else $error("taken relative jump has wrong state count");

  AST_REL_NOT_TAKEN: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (s_reg.st == ST_DISP && s_reg.t == T_SAMPLE &&
     s_reg.op == OP_REL_NZ && zero_flag_i)
    |=> done_o && mcycle_count_o == 2'h2 &&
        tstate_count_o == TT_REL_NOT &&
        program_counter_o == $past(s_reg.pc) + 16'h0001)
    else $error("relative jump with zero set did not fall through");

  AST_REACH: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (done_o && s_reg.mc == 2'h3)
    |-> (16'(program_counter_o - s_reg.op_addr + 16'h007E) <= 16'h00FF))
    else $error("branch target outside reach");

  AST_DISP_ADD: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (s_reg.st == ST_DISP && s_reg.t == T_SAMPLE && s_next.st == ST_ADD)
    |-> ##6 (done_o && program_counter_o == $past(s_reg.op_addr, 6) +
             16'h0002 + {{8{$past(mem_data_i[7], 6)}},
             $past(mem_data_i, 6)}))
    else $error("displacement not added to advanced counter");

  AST_SIGN_EXT: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (done_o && s_reg.mc == 2'h3 && s_reg.disp[7])
    |-> (16'(program_counter_o - s_reg.op_addr - 16'h0002) >= 16'hFF80))
    else $error("negative displacement did not move backward");

  AST_PTR_JUMP: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (done_o && s_reg.mc == 2'h1 && !unsupported_o)
    |-> (tstate_count_o == TT_PTR &&
         program_counter_o == $past(pointer_pair_i)))
    else $error("pointer pair jump wrong");

  AST_FIRST_INDEX: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (s_reg.st == ST_PFX && s_reg.t == 3'h3 && s_reg.op == OP_JUMP_PTR &&
     !s_reg.second_sel)
    |=> done_o && tstate_count_o == TT_INDEX &&
        program_counter_o == $past(first_index_i))
    else $error("first index jump wrong");

  AST_SECOND_INDEX: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (s_reg.st == ST_PFX && s_reg.t == 3'h3 && s_reg.op == OP_JUMP_PTR &&
     s_reg.second_sel)
    |=> done_o && tstate_count_o == TT_INDEX &&
        program_counter_o == $past(second_index_i))
    else $error("second index jump wrong");

  AST_LOOP_TAKEN: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (done_o && s_reg.op == OP_LOOP && s_reg.mc == 2'h3)
    |-> (tstate_count_o == TT_LOOP_TAKEN && loop_count_o != 8'h00))
    else $error("taken loop branch wrong");

  AST_LOOP_FALL: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (done_o && s_reg.op == OP_LOOP && s_reg.mc == 2'h2)
    |-> (tstate_count_o == TT_LOOP_NOT && loop_count_o == 8'h00))
    else $error("loop fall through wrong");

  AST_LOOP_COUNTER: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (s_reg.st == ST_FETCH && s_reg.t == 3'h4 && s_reg.op == OP_LOOP)
    |=> loop_count_we_o && loop_count_o == $past(loop_count_i) - 8'h01
        ##3 ((s_reg.st == ST_ADD) == (loop_count_o != 8'h00)))
    else $error("loop decision not on decremented counter");

endmodule : cbe_branch_unit

// File: rtl/cbe_pkg.sv
/*
  Constants and types shared by the branch execution unit: opcodes,
  clock-state lengths of each machine cycle and the sequencer states.
  Assumes one clock cycle of the core clock equals one clock state.
*/
package cbe_pkg;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_REL_NZ = 8'h20;
  localparam logic [7:0] OP_LOOP = 8'h10;
  localparam logic [7:0] OP_JUMP_PTR = 8'hE9;
  localparam logic [7:0] OP_PFX_FIRST = 8'hDD;
  localparam logic [7:0] OP_PFX_SECOND = 8'hFD;

  // ---------------------------------------------------------------
  // Clock states per machine cycle
  // ---------------------------------------------------------------
  localparam logic [2:0] T_FETCH = 3'h4;
  localparam logic [2:0] T_FETCH_LOOP = 3'h5;
  localparam logic [2:0] T_READ = 3'h3;
  localparam logic [2:0] T_ADD = 3'h5;
  localparam logic [2:0] T_SAMPLE = 3'h2;

  // ---------------------------------------------------------------
  // Totals reported at completion
  // ---------------------------------------------------------------
  localparam logic [3:0] TT_REL_TAKEN = 4'hC;
  localparam logic [3:0] TT_REL_NOT = 4'h7;
  localparam logic [3:0] TT_PTR = 4'h4;
  localparam logic [3:0] TT_INDEX = 4'h8;
  localparam logic [3:0] TT_LOOP_TAKEN = 4'hD;
  localparam logic [3:0] TT_LOOP_NOT = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_PFX,
    ST_DISP,
    ST_ADD
  } cbe_state_e;

endpackage : cbe_pkg

// File: verif/cbe_prog_mem.sv
/*
  Program memory model for the branch execution unit bench.
  Assumes the bench fills mem before each start and that the unit
  samples a byte only while its read strobe is high.
*/
module cbe_prog_mem (
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];

  // Outside a read the bus shows inverted data, so a stray sample shows.
  assign data_o = rd_i ? mem[addr_i] : ~mem[addr_i];
endmodule // cbe_prog_mem

// File: verif/cpu_branch_execution_bench.sv
/*
  Self-checking bench for the branch execution unit.
  Assumes the program memory model answers within the read cycle.
*/
module cpu_branch_execution_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cbe_pkg::*;
  logic clock_i = 0, rst_i = 1, start_i = 0, zero_flag_i = 0;
  logic [15:0] pc_i = 0, pp = 0, fi = 0, si = 0;
  logic [7:0] loop_count_i = 0, mem_data_i;
  logic [15:0] mem_addr_o, program_counter_o;
  logic mem_rd_o, busy_o, done_o, unsupported_o, loop_count_we_o;
  logic [7:0] loop_count_o;
  logic [3:0] tstate_count_o;
  logic [1:0] mcycle_count_o;
  integer errors = 0, num_checks = 0, seed = 74, i, k;
  logic [15:0] a;
  logic [7:0] d, c;

  cbe_branch_unit dut_u (.clock_i(clock_i), .rst_i(rst_i),
    .start_i(start_i), .pc_i(pc_i), .zero_flag_i(zero_flag_i),
    .loop_count_i(loop_count_i), .pointer_pair_i(pp),
    .first_index_i(fi), .second_index_i(si), .mem_data_i(mem_data_i),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .busy_o(busy_o),
    .done_o(done_o), .unsupported_o(unsupported_o),
    .program_counter_o(program_counter_o), .loop_count_o(loop_count_o),
    .loop_count_we_o(loop_count_we_o), .tstate_count_o(tstate_count_o),
    .mcycle_count_o(mcycle_count_o));
  cbe_prog_mem mem_u (.addr_i(mem_addr_o), .rd_i(mem_rd_o),
    .data_o(mem_data_i));

  initial begin
    forever #2 clock_i = ~clock_i;
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic logic [15:0] target(input logic [15:0] at,
                                         input logic [7:0] disp);
    return at + 16'h0002 + {{8{disp[7]}}, disp};
  endfunction

  task automatic run(input logic [7:0] b0, b1, input logic [15:0] at,
    input logic z, input logic [7:0] cnt, input logic [15:0] epc,
    input logic [3:0] et, input logic [1:0] em, input logic eu, ewe);
    integer n, wes;
    mem_u.mem[at] = b0;
    mem_u.mem[at + 16'h0001] = b1;
    @(posedge clock_i);
    start_i <= 1;
    pc_i <= at;
    zero_flag_i <= z;
    loop_count_i <= cnt;
    @(posedge clock_i);
    start_i <= 0;
    n = 0;
    wes = 0;
    do begin
      @(negedge clock_i);
      n++;
      if (loop_count_we_o === 1'b1) wes++;
    end while (done_o !== 1'b1 && n < 40);
    check("done_delay", 16'(n - 1), {12'h000, et});
    check("program_counter", program_counter_o, epc);
    check("fetch_address", mem_addr_o, epc);
    check("read_idle", {15'h0000, mem_rd_o}, 16'h0000);
    check("tstates", tstate_count_o, et);
    if (!eu) check("mcycles", mcycle_count_o, em);
    check("unsupported", unsupported_o, eu);
    check("count_write", wes, ewe);
    if (ewe) check("loop_count", loop_count_o, 8'(cnt - 8'h01));
  endtask

  task automatic rel(input logic [15:0] at, input logic [7:0] disp,
                     input logic z);
    run(OP_REL_NZ, disp, at, z, 8'h00, z ? at + 16'h0002 :
        target(at, disp), z ? 4'h7 : 4'hC, z ? 2'h2 : 2'h3, 1'b0, 1'b0);
  endtask

  task automatic loop(input logic [15:0] at, input logic [7:0] disp,
                      input logic [7:0] cnt);
    logic nz;
    nz = (cnt != 8'h01);
    // Zero flag drawn at random: the loop must ignore it.
    run(OP_LOOP, disp, at, 1'($random(seed)), cnt, nz ? target(at, disp) :
        at + 16'h0002, nz ? 4'hD : 4'h8, nz ? 2'h3 : 2'h2, 1'b0,
        1'b1);
  endtask

  task automatic indirect(input integer which, input logic [15:0] at);
    logic [15:0] v0, v1, v2;
    v0 = 16'($random(seed));
    v1 = 16'($random(seed));
    v2 = 16'($random(seed));
    @(posedge clock_i);
    pp <= v0;
    fi <= v1;
    si <= v2;
    case (which)
      0: run(OP_JUMP_PTR, 8'h00, at, 1'b0, 8'h00, v0, 4'h4, 2'h1,
             1'b0, 1'b0);
      1: run(OP_PFX_FIRST, OP_JUMP_PTR, at, 1'b1, 8'h00, v1, 4'h8, 2'h2,
             1'b0, 1'b0);
      default: run(OP_PFX_SECOND, OP_JUMP_PTR, at, 1'b0, 8'h00, v2, 4'h8,
                   2'h2, 1'b0, 1'b0);
    endcase
  endtask

  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 0;
    @(negedge clock_i);
    check("busy_after_reset", {15'h0000, busy_o}, 16'h0000);
    check("done_after_reset", {15'h0000, done_o}, 16'h0000);
    rel(16'h0480, 8'hFA, 0);
    rel(16'h1000, 8'h80, 0);
    rel(16'h1000, 8'h7F, 0);
    rel(16'hFFFF, 8'h05, 1);
    loop(16'h2000, 8'hF0, 8'h01);
    loop(16'h2000, 8'hF0, 8'h00);
    loop(16'h2000, 8'h10, 8'h02);
    for (k = 0; k < 3; k++) indirect(k, 16'h3000);
    run(8'h00, 8'h00, 16'h4000, 1'b0, 8'h00, 16'h4001, 4'h4, 2'h0, 1'b1,
        1'b0);
    for (i = 0; i < 80; i++) begin
      a = $random(seed);
      d = $random(seed);
      c = $random(seed);
      k = $unsigned($random(seed)) % 5;
      case (k)
        0: rel(a, d, c[0]);
        1: loop(a, d, c);
        default: indirect(k - 2, a);
      endcase
    end
    complete_run;
  end

  initial begin
    #40000;
    errors++;
    complete_run;
  end
endmodule // cpu_branch_execution_bench
